/* File: include/dsm_pkg.sv */
// package: constants, types and register map of the drive device state machine
package dsm_pkg;

  // ************************************************************
  // device states
  // ************************************************************
  typedef enum logic [2:0] {
    DSM_NOT_READY,
    DSM_SWITCH_ON_DISABLED,
    DSM_READY_TO_SWITCH_ON,
    DSM_SWITCHED_ON,
    DSM_OPERATION_ENABLED,
    DSM_QUICK_STOP_ACTIVE,
    DSM_FAULT_REACTION,
    DSM_FAULT
  } dsm_state_t;

  // ************************************************************
  // register map (byte addresses, one word each)
  // ************************************************************
  localparam logic [7:0] DSM_CFG_ADDR      = 8'h00;
  localparam logic [7:0] DSM_OFFDLY_ADDR   = 8'h04;
  localparam logic [7:0] DSM_QSMAX_ADDR    = 8'h08;
  localparam logic [7:0] DSM_CTRL_ADDR     = 8'h0C;
  localparam logic [7:0] DSM_STATE_ADDR    = 8'h10;
  localparam logic [7:0] DSM_LOCKOUT_ADDR  = 8'h14;

  // configuration field positions
  localparam int DSM_CFG_AUTO_RUN_BIT   = 0;
  localparam int DSM_CFG_QS_ENLOSS_BIT  = 1;
  localparam int DSM_CFG_QS_END_BIT     = 2;
  localparam int DSM_CFG_QS_FAULT_BIT   = 3;
  localparam int DSM_CFG_EXTRA_SRC_BIT  = 4;
  // control register field positions
  localparam int DSM_CTRL_EXTRA_EN_BIT  = 0;
  localparam int DSM_CTRL_FAULT_ACK_BIT = 1;
  localparam int DSM_CTRL_QS_REQ_BIT    = 2;

  // reset values
  localparam logic [4:0]  DSM_CFG_RST    = 5'h00;
  localparam logic [23:0] DSM_OFFDLY_RST = 24'h000000;
  localparam logic [23:0] DSM_QSMAX_RST  = 24'h0F4240;
  localparam logic [2:0]  DSM_CTRL_RST   = 3'h0;

  // delay counters tick in microseconds: 50 cycles at 50 MHz
  localparam int          DSM_CLK_MHZ     = 50;
  localparam int          DSM_TICK_US     = 1;
  localparam logic [5:0]  DSM_TICK_CYCLES = 6'(DSM_TICK_US * DSM_CLK_MHZ - 1);

  // lockout cause inputs, one bit each
  typedef struct packed {
    logic safety_active;
    logic motion_bus_down;
    logic axis_not_ready;
    logic supply_low;
  } dsm_lockout_t;

  // outputs controlling the power stage
  typedef struct packed {
    logic power_on;
    logic drive_enabled;
    logic activation_enabled;
    logic brake_release;
    logic quick_stop_exec;
    logic coast;
  } dsm_ctrl_out_t;

endpackage : dsm_pkg

/* File: rtl/dsm_top.sv */
// drive device state machine with APB register slave
`timescale 1ns/1ps

// ************************************************************
// drive device state machine
// ************************************************************
// Operation
// - during self-test keep power, drive and activation locked and brakes engaged
// - after successful self-test, go from not-ready to switch-on-disabled
// - hold switch-on-disabled while any lockout cause is present
// - without lockout causes, move to ready-to-switch-on automatically
// - auto run with enable present jumps directly to operation-enabled
// - ready-to-switch-on: power and drive locked, activation enabled
// - ready: enable goes to switched-on, lockout goes to switch-on-disabled
// - effective enable is terminal enable AND extra enable
// - switched-on: power on, set values ignored, no torque
// - switched-on: enable to operation, no enable to ready, lockout to disabled
// - operation-enabled processes set values, brakes release on first motion command
// - operation: quick stop request, enable loss, lockout each have their target
// - terminal enable counts off only after staying low past the delay
// - enable loss goes to quick stop if configured, else ready
// - quick stop: cancel returns, completion without enable readies, lockout disables
// - quick stop on enable loss switches power off after maximum duration
// - configuration selects quick stop end by standstill or by request withdrawal
// - after fault response, enter fault automatically
// - on fault do quick stop if configured, else stop controlling motion
// - fault goes to switch-on-disabled after cause removed and acknowledged
// - current state and exact lockout cause are readable
module dsm_top
  import dsm_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rstn,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // drive side
  input  wire logic          self_test_done,
  input  wire logic          terminal_enable_input,
  input  wire logic          extra_enable_input,
  input  wire logic          quickstop_request,
  input  wire dsm_lockout_t  lockout_in,
  input  wire logic          drive_error,
  input  wire logic          fault_cause_active,
  input  wire logic          fault_response_done,
  input  wire logic          standstill,
  input  wire logic          motion_cmd_active,
  output dsm_ctrl_out_t      ctrl_out,
  output dsm_state_t         device_state_indication
);

  // ************************************************************
  // registers
  // ************************************************************
  logic [4:0]    cfg_reg;
  logic [23:0]   enable_off_delay_reg;
  logic [23:0]   quickstop_max_duration_reg;
  logic [2:0]    device_control_byte_reg;
  dsm_state_t    state_reg;
  dsm_state_t    state_next;
  logic [5:0]    tick_cnt_reg;
  logic [23:0]   off_cnt_reg;
  logic          term_off_reg;
  logic [23:0]   qs_cnt_reg;
  logic          qs_by_enloss_reg;
  logic          qs_timeout_reg;
  logic          brake_rel_reg;
  logic          ack_seen_reg;
  dsm_ctrl_out_t ctrl_next;

  // ************************************************************
  // apb decode
  // ************************************************************
  wire wr_en     = psel & penable & pwrite;
  wire rd_en     = psel & penable & ~pwrite;
  wire hit_cfg   = (paddr == DSM_CFG_ADDR);
  wire hit_off   = (paddr == DSM_OFFDLY_ADDR);
  wire hit_qsmax = (paddr == DSM_QSMAX_ADDR);
  wire hit_ctrl  = (paddr == DSM_CTRL_ADDR);
  wire hit_state = (paddr == DSM_STATE_ADDR);
  wire hit_lock  = (paddr == DSM_LOCKOUT_ADDR);
  wire hit_any   = hit_cfg | hit_off | hit_qsmax | hit_ctrl | hit_state | hit_lock;
  // the acknowledge strobe counts only at the completing edge of the write
  wire ack_wr    = wr_en & pready & hit_ctrl & pwdata[DSM_CTRL_FAULT_ACK_BIT];

  wire [31:0] rd_mux =
    hit_cfg   ? {27'h0000000, cfg_reg} :
    hit_off   ? {8'h00, enable_off_delay_reg} :
    hit_qsmax ? {8'h00, quickstop_max_duration_reg} :
    hit_ctrl  ? {29'h00000000, device_control_byte_reg} :
    hit_state ? {29'h00000000, state_reg} :
    hit_lock  ? {28'h0000000, lockout_in} : 32'h00000000;

  // ************************************************************
  // configuration decode
  // ************************************************************
  wire auto_run_select          = cfg_reg[DSM_CFG_AUTO_RUN_BIT];
  wire quickstop_on_enable_loss = cfg_reg[DSM_CFG_QS_ENLOSS_BIT];
  wire quickstop_end_select     = cfg_reg[DSM_CFG_QS_END_BIT];
  wire quickstop_on_fault       = cfg_reg[DSM_CFG_QS_FAULT_BIT];
  wire extra_enable_source      = cfg_reg[DSM_CFG_EXTRA_SRC_BIT];

  // fieldbus extra enable comes from control byte bit 0
  wire extra_en = extra_enable_source ? device_control_byte_reg[DSM_CTRL_EXTRA_EN_BIT]
                                      : extra_enable_input;
  wire qs_req   = quickstop_request | device_control_byte_reg[DSM_CTRL_QS_REQ_BIT];

  // filtered terminal enable ANDed with the extra enable
  wire enable_eff = ~term_off_reg & extra_en;
  wire lockout    = |lockout_in;
  wire tick       = (tick_cnt_reg == DSM_TICK_CYCLES);

  // quick stop end: standstill, or withdrawal of the request
  wire qs_done = quickstop_end_select ? ~qs_req : standstill;

  // ************************************************************
  // apb registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_reg                    <= DSM_CFG_RST;
      enable_off_delay_reg       <= DSM_OFFDLY_RST;
      quickstop_max_duration_reg <= DSM_QSMAX_RST;
      device_control_byte_reg    <= DSM_CTRL_RST;
      prdata                     <= 32'h00000000;
      pready                     <= 1'b0;
      pslverr                    <= 1'b0;
    end else begin
      // one wait state: the answer comes in the second access cycle
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit_any;
      if (rd_en & ~pready) begin
        prdata <= rd_mux;
      end
      if (wr_en & pready) begin
        if (hit_cfg)   cfg_reg                    <= pwdata[4:0];
        if (hit_off)   enable_off_delay_reg       <= pwdata[23:0];
        if (hit_qsmax) quickstop_max_duration_reg <= pwdata[23:0];
        // acknowledge bit is a strobe, never stored
        if (hit_ctrl)  device_control_byte_reg    <= {pwdata[2], 1'b0, pwdata[0]};
      end
    end
  end

  // ************************************************************
  // enable-off filter and quick stop timer
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tick_cnt_reg <= 6'h00;
      off_cnt_reg  <= 24'h000000;
      term_off_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick ? 6'h00 : tick_cnt_reg + 6'h01;
      if (terminal_enable_input) begin
        off_cnt_reg  <= 24'h000000;
        term_off_reg <= 1'b0;
      end else if (off_cnt_reg > enable_off_delay_reg) begin
        // low longer than the delay: test pulses never get here
        term_off_reg <= 1'b1;
      end else if (tick) begin
        off_cnt_reg <= off_cnt_reg + 24'h000001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      qs_cnt_reg     <= 24'h000000;
      qs_timeout_reg <= 1'b0;
    end else if (state_reg != DSM_QUICK_STOP_ACTIVE || !qs_by_enloss_reg) begin
      qs_cnt_reg     <= 24'h000000;
      qs_timeout_reg <= 1'b0;
    end else if (qs_cnt_reg >= quickstop_max_duration_reg) begin
      qs_timeout_reg <= 1'b1;
    end else if (tick) begin
      qs_cnt_reg <= qs_cnt_reg + 24'h000001;
    end
  end

  // ************************************************************
  // state transitions
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      DSM_NOT_READY: begin
        if (self_test_done) state_next = DSM_SWITCH_ON_DISABLED;
      end
      DSM_SWITCH_ON_DISABLED: begin
        if (lockout) state_next = DSM_SWITCH_ON_DISABLED;
        else if (auto_run_select && enable_eff) state_next = DSM_OPERATION_ENABLED;
        else state_next = DSM_READY_TO_SWITCH_ON;
      end
      DSM_READY_TO_SWITCH_ON: begin
        if (lockout) state_next = DSM_SWITCH_ON_DISABLED;
        else if (enable_eff) state_next = DSM_SWITCHED_ON;
      end
      DSM_SWITCHED_ON: begin
        if (lockout) state_next = DSM_SWITCH_ON_DISABLED;
        else if (enable_eff) state_next = DSM_OPERATION_ENABLED;
        else state_next = DSM_READY_TO_SWITCH_ON;
      end
      DSM_OPERATION_ENABLED: begin
        if (lockout) state_next = DSM_SWITCH_ON_DISABLED;
        else if (qs_req) state_next = DSM_QUICK_STOP_ACTIVE;
        else if (!enable_eff) state_next = quickstop_on_enable_loss ? DSM_QUICK_STOP_ACTIVE
                                                                    : DSM_READY_TO_SWITCH_ON;
      end
      DSM_QUICK_STOP_ACTIVE: begin
        if (lockout) state_next = DSM_SWITCH_ON_DISABLED;
        else if (!enable_eff && (qs_done || qs_timeout_reg)) state_next = DSM_READY_TO_SWITCH_ON;
        else if (enable_eff && !qs_req) state_next = DSM_OPERATION_ENABLED;
      end
      DSM_FAULT_REACTION: begin
        if (fault_response_done) state_next = DSM_FAULT;
      end
      DSM_FAULT: begin
        if (ack_seen_reg && !fault_cause_active) state_next = DSM_SWITCH_ON_DISABLED;
      end
    endcase
    // a drive error overrides every state that has left self-test, except fault reaction and fault
    if (drive_error && state_reg != DSM_NOT_READY && state_reg != DSM_FAULT
        && state_reg != DSM_FAULT_REACTION) begin
      state_next = DSM_FAULT_REACTION;
    end
  end

  // ************************************************************
  // power stage outputs
  // ************************************************************
  always_comb begin
    ctrl_next = '0;
    unique case (state_next)
      DSM_NOT_READY, DSM_SWITCH_ON_DISABLED, DSM_FAULT: ctrl_next = '0;
      DSM_READY_TO_SWITCH_ON: ctrl_next.activation_enabled = 1'b1;
      DSM_SWITCHED_ON: begin
        ctrl_next.power_on           = 1'b1;
        ctrl_next.activation_enabled = 1'b1;
      end
      DSM_OPERATION_ENABLED: begin
        ctrl_next.power_on           = 1'b1;
        ctrl_next.activation_enabled = 1'b1;
        ctrl_next.drive_enabled      = 1'b1;
        ctrl_next.brake_release      = brake_rel_reg | motion_cmd_active;
      end
      DSM_QUICK_STOP_ACTIVE: begin
        // power drops once the enable-loss stop overruns its budget
        ctrl_next.power_on           = ~qs_timeout_reg;
        ctrl_next.activation_enabled = 1'b1;
        ctrl_next.drive_enabled      = ~qs_timeout_reg;
        ctrl_next.brake_release      = brake_rel_reg & ~qs_timeout_reg;
        ctrl_next.quick_stop_exec    = 1'b1;
      end
      DSM_FAULT_REACTION: begin
        ctrl_next.power_on        = quickstop_on_fault;
        ctrl_next.drive_enabled   = quickstop_on_fault;
        ctrl_next.brake_release   = quickstop_on_fault & brake_rel_reg;
        ctrl_next.quick_stop_exec = quickstop_on_fault;
        ctrl_next.coast           = ~quickstop_on_fault;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg               <= DSM_NOT_READY;
      device_state_indication <= DSM_NOT_READY;
      ctrl_out                <= '0;
      qs_by_enloss_reg        <= 1'b0;
      brake_rel_reg           <= 1'b0;
      ack_seen_reg            <= 1'b0;
    end else begin
      state_reg               <= state_next;
      // indication follows the same edge as the state itself
      device_state_indication <= state_next;
      ctrl_out                <= ctrl_next;
      brake_rel_reg           <= ctrl_next.brake_release;
      if (state_reg == DSM_OPERATION_ENABLED && state_next == DSM_QUICK_STOP_ACTIVE) begin
        qs_by_enloss_reg <= ~qs_req;
      end
      // ack only counts while in fault; cleared on leaving
      // an ack given while the cause persists is dropped: the cause must go first
      if (state_reg != DSM_FAULT) ack_seen_reg <= 1'b0;
      else if (ack_wr && !fault_cause_active) ack_seen_reg <= 1'b1;
    end
  end

endmodule : dsm_top

/* File: testbench/dsm_chk.sv */
// checker: port-level properties of the drive device state machine
`timescale 1ns/1ps
module dsm_chk
  import dsm_pkg::*;
(
  input wire logic          clk,
  input wire logic          rstn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pready,
  input wire logic          self_test_done,
  input wire dsm_lockout_t  lockout_in,
  input wire logic          drive_error,
  input wire logic          fault_cause_active,
  input wire logic          fault_response_done,
  input wire logic          motion_cmd_active,
  input wire dsm_ctrl_out_t ctrl_out,
  input wire dsm_state_t    device_state_indication
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  dsm_state_t st;
  assign st = device_state_indication;
  // drive error is left out of the lockout antecedents: it overrides lockout and leads to fault reaction
  wire lk  = |lockout_in;
  wire run = st inside {DSM_READY_TO_SWITCH_ON, DSM_SWITCHED_ON, DSM_OPERATION_ENABLED, DSM_QUICK_STOP_ACTIVE};
  wire pw  = run || st == DSM_SWITCH_ON_DISABLED;
  property p_nready; st == DSM_NOT_READY |-> ctrl_out[5:2] == 4'h0; endproperty
  a_nready: assert property (p_nready) else $error("outputs active before self test");
  property p_selftest; st == DSM_NOT_READY && self_test_done |=> st == DSM_SWITCH_ON_DISABLED; endproperty
  a_selftest: assert property (p_selftest) else $error("self test exit missing");
  property p_hold; st == DSM_SWITCH_ON_DISABLED && lk && !drive_error |=> st == DSM_SWITCH_ON_DISABLED; endproperty
  a_hold: assert property (p_hold) else $error("left disabled under lockout");
  property p_ready; st == DSM_READY_TO_SWITCH_ON |-> ctrl_out[5:2] == 4'h2; endproperty
  a_ready: assert property (p_ready) else $error("ready outputs wrong");
  property p_swon; st == DSM_SWITCHED_ON |-> ctrl_out[5:4] == 2'h2 && !ctrl_out.brake_release; endproperty
  a_swon: assert property (p_swon) else $error("switched on outputs wrong");
  property p_lkexit; run && lk && !drive_error |=> st == DSM_SWITCH_ON_DISABLED; endproperty
  a_lkexit: assert property (p_lkexit) else $error("lockout not obeyed");
  property p_brake; $rose(ctrl_out.brake_release) && st == DSM_OPERATION_ENABLED |-> $past(motion_cmd_active); endproperty
  a_brake: assert property (p_brake) else $error("brake released without motion");
  property p_err; pw && drive_error && !lk |=> st == DSM_FAULT_REACTION; endproperty
  a_err: assert property (p_err) else $error("drive error not taken");
  property p_frdone; st == DSM_FAULT_REACTION && fault_response_done |=> st == DSM_FAULT; endproperty
  a_frdone: assert property (p_frdone) else $error("fault state not entered");
  property p_fhold; st == DSM_FAULT && fault_cause_active |=> st == DSM_FAULT; endproperty
  a_fhold: assert property (p_fhold) else $error("fault left with cause active");
  property p_apb; psel && penable && !pready |=> pready; endproperty
  a_apb: assert property (p_apb) else $error("register answer late");
endmodule : dsm_chk

bind dsm_top dsm_chk i_chk (.clk, .rstn, .psel, .penable, .pready, .self_test_done, .lockout_in, .drive_error,
  .fault_cause_active, .fault_response_done, .motion_cmd_active, .ctrl_out, .device_state_indication);

/* File: testbench/dsm_ctl_model.sv */
// partner model: machine controller driving the enable and quick stop lines
`timescale 1ns/1ps
module dsm_ctl_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       want_en,
  input  wire logic       want_x,
  input  wire logic       want_qs,
  input  wire logic       pulse_go,
  input  wire logic [7:0] pulse_len,
  output logic            terminal_enable_input,
  output logic            extra_enable_input,
  output logic            quickstop_request
);
  logic [7:0] low_reg;
  // safety relay test pulse: line dips low while the controller still wants enable
  always_ff @(posedge clk) begin
    if (!rstn) begin
      low_reg <= 8'h00;
    end else if (pulse_go) begin
      low_reg <= pulse_len;
    end else if (low_reg != 8'h00) begin
      low_reg <= low_reg - 8'h01;
    end
  end
  assign terminal_enable_input = want_en && low_reg == 8'h00;
  assign extra_enable_input    = want_x;
  assign quickstop_request     = want_qs;
endmodule : dsm_ctl_model

/* File: testbench/tb_drive_device_state_machine.sv */
// testbench: directed scenarios for the drive device state machine
`timescale 1ns/1ps
module tb_drive_device_state_machine import dsm_pkg::*; ;
  logic          clk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pulse_go = 1'h0;
  logic          self_test_done = 1'h0, want_en = 1'h0, want_x = 1'h0, want_qs = 1'h0, standstill = 1'h0;
  logic          drive_error = 1'h0, fault_cause_active = 1'h0, fault_response_done = 1'h0, motion_cmd_active = 1'h0;
  logic [7:0]    paddr = 8'h00, pulse_len = 8'h00;
  logic [31:0]   pwdata = 32'h0, prdata, rd;
  logic          pready, pslverr, slverr_q, ten, xen, qsr;
  logic [1:0]    swon_out;
  dsm_lockout_t  lockout_in = 4'h0;
  dsm_ctrl_out_t ctrl_out;
  dsm_state_t    st;
  int            err_total = 0, n_compared = 0, n_ready = 0, k;

  dsm_ctl_model i_ctl (.clk, .rstn, .want_en, .want_x, .want_qs, .pulse_go, .pulse_len,
    .terminal_enable_input(ten), .extra_enable_input(xen), .quickstop_request(qsr));
  dsm_top i_dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .self_test_done, .terminal_enable_input(ten), .extra_enable_input(xen), .quickstop_request(qsr),
    .lockout_in, .drive_error, .fault_cause_active, .fault_response_done, .standstill, .motion_cmd_active,
    .ctrl_out, .device_state_indication(st));

  always #10 clk = ~clk;
  // switched-on lasts a single cycle, so it is captured here rather than polled
  always @(posedge clk) begin
    if (st == DSM_READY_TO_SWITCH_ON) n_ready++;
    if (st == DSM_SWITCHED_ON) swon_out = ctrl_out[5:4];
  end

  // ********************
  // shared tasks
  // ********************
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string w, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", w, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n); repeat (n) @(posedge clk); endtask : cyc
  task automatic is_st(input string w, input dsm_state_t s); chk(w, 32'(st), 32'(s)); endtask : is_st

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'h1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    slverr_q = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      err_total++;
      final_report();
    end
    @(posedge clk);
  endtask : apb

  task automatic wait_st(input dsm_state_t s, input int lim);
    int n;
    n = 0;
    while (st !== s && n < lim) begin
      @(posedge clk);
      n++;
    end
    is_st("state", s);
    if (st !== s) final_report();
  endtask : wait_st

  // ********************
  // scenarios
  // ********************
  task automatic s_regs();
    apb(1'h0, DSM_QSMAX_ADDR, 32'h0);
    chk("qsmax", rd, 32'(DSM_QSMAX_RST));
    apb(1'h0, DSM_STATE_ADDR, 32'h0);
    chk("state reg", rd, 32'(DSM_NOT_READY));
    chk("locked", 32'(ctrl_out[5:2]), 32'h0);
    apb(1'h0, 8'h18, 32'h0);
    chk("unmapped", {rd[30:0], slverr_q}, 32'h1);
  endtask : s_regs

  task automatic s_power();
    lockout_in <= 4'h1;
    self_test_done <= 1'h1;
    wait_st(DSM_SWITCH_ON_DISABLED, 10);
    cyc(10);
    is_st("held", DSM_SWITCH_ON_DISABLED);
    apb(1'h0, DSM_LOCKOUT_ADDR, 32'h0);
    chk("cause", rd, 32'h1);
    lockout_in <= 4'h0;
    wait_st(DSM_READY_TO_SWITCH_ON, 10);
    chk("ready out", 32'(ctrl_out[5:2]), 32'h2);
  endtask : s_power

  task automatic s_enable();
    apb(1'h1, DSM_CFG_ADDR, 32'h10);
    want_en <= 1'h1;
    want_x <= 1'h1;
    cyc(20);
    is_st("no extra", DSM_READY_TO_SWITCH_ON);
    apb(1'h1, DSM_CTRL_ADDR, 32'h1);
    wait_st(DSM_OPERATION_ENABLED, 10);
    chk("swon out", 32'(swon_out), 32'h2);
    chk("brake held", 32'(ctrl_out.brake_release), 32'h0);
    motion_cmd_active <= 1'h1;
    cyc(3);
    chk("run out", 32'({ctrl_out[5:4], ctrl_out[2]}), 32'h7);
    apb(1'h1, DSM_CFG_ADDR, 32'h0);
    want_x <= 1'h0;
    wait_st(DSM_READY_TO_SWITCH_ON, 10);
    want_x <= 1'h1;
    wait_st(DSM_OPERATION_ENABLED, 10);
  endtask : s_enable

  task automatic s_filter();
    apb(1'h1, DSM_OFFDLY_ADDR, 32'h3);
    pulse_len <= 8'h3C;
    pulse_go <= 1'h1;
    @(posedge clk);
    pulse_go <= 1'h0;
    cyc(150);
    is_st("pulse", DSM_OPERATION_ENABLED);
    want_en <= 1'h0;
    cyc(140);
    is_st("in delay", DSM_OPERATION_ENABLED);
    wait_st(DSM_READY_TO_SWITCH_ON, 200);
    want_en <= 1'h1;
    wait_st(DSM_OPERATION_ENABLED, 20);
  endtask : s_filter

  task automatic s_qs();
    apb(1'h1, DSM_CFG_ADDR, 32'h4);
    want_qs <= 1'h1;
    wait_st(DSM_QUICK_STOP_ACTIVE, 10);
    chk("qs exec", 32'(ctrl_out.quick_stop_exec), 32'h1);
    standstill <= 1'h1;
    want_x <= 1'h0;
    cyc(10);
    is_st("end by withdrawal", DSM_QUICK_STOP_ACTIVE);
    standstill <= 1'h0;
    want_x <= 1'h1;
    want_qs <= 1'h0;
    wait_st(DSM_OPERATION_ENABLED, 10);
    apb(1'h1, DSM_CFG_ADDR, 32'h0);
    apb(1'h1, DSM_CTRL_ADDR, 32'h4);
    wait_st(DSM_QUICK_STOP_ACTIVE, 10);
    apb(1'h1, DSM_CTRL_ADDR, 32'h0);
    wait_st(DSM_OPERATION_ENABLED, 10);
  endtask : s_qs

  task automatic s_enloss();
    apb(1'h1, DSM_QSMAX_ADDR, 32'h2);
    apb(1'h1, DSM_CFG_ADDR, 32'h2);
    want_en <= 1'h0;
    wait_st(DSM_QUICK_STOP_ACTIVE, 300);
    cyc(40);
    chk("power kept", 32'(ctrl_out.power_on), 32'h1);
    for (k = 0; k < 200 && ctrl_out.power_on !== 1'h0; k++) @(posedge clk);
    chk("power cut", 32'(ctrl_out.power_on), 32'h0);
    standstill <= 1'h1;
    wait_st(DSM_READY_TO_SWITCH_ON, 20);
    standstill <= 1'h0;
    want_en <= 1'h1;
    wait_st(DSM_OPERATION_ENABLED, 20);
  endtask : s_enloss

  task automatic s_lock();
    for (int i = 0; i < 4; i++) begin
      lockout_in <= dsm_lockout_t'(4'h1 << i);
      wait_st(DSM_SWITCH_ON_DISABLED, 10);
      apb(1'h0, DSM_LOCKOUT_ADDR, 32'h0);
      chk("cause", rd, 32'h1 << i);
      lockout_in <= 4'h0;
      wait_st(DSM_OPERATION_ENABLED, 20);
    end
  endtask : s_lock

  task automatic s_fault();
    for (int q = 0; q < 2; q++) begin
      apb(1'h1, DSM_CFG_ADDR, 32'(q) << 3);
      drive_error <= 1'h1;
      wait_st(DSM_FAULT_REACTION, 10);
      chk("fault stop", 32'({ctrl_out.quick_stop_exec, ctrl_out.coast}), (q == 1) ? 32'h2 : 32'h1);
      drive_error <= 1'h0;
      fault_cause_active <= 1'h1;
      fault_response_done <= 1'h1;
      wait_st(DSM_FAULT, 10);
      fault_response_done <= 1'h0;
      apb(1'h1, DSM_CTRL_ADDR, 32'h2);
      cyc(5);
      is_st("cause present", DSM_FAULT);
      fault_cause_active <= 1'h0;
      cyc(3);
      is_st("ack before removal", DSM_FAULT);
      apb(1'h1, DSM_CTRL_ADDR, 32'h2);
      wait_st(DSM_SWITCH_ON_DISABLED, 10);
      wait_st(DSM_OPERATION_ENABLED, 20);
    end
  endtask : s_fault

  task automatic s_auto();
    apb(1'h1, DSM_CFG_ADDR, 32'h1);
    lockout_in <= 4'h8;
    wait_st(DSM_SWITCH_ON_DISABLED, 10);
    k = n_ready;
    lockout_in <= 4'h0;
    wait_st(DSM_OPERATION_ENABLED, 10);
    chk("ready skipped", 32'(n_ready - k), 32'h0);
  endtask : s_auto

  initial begin
    cyc(12);
    rstn <= 1'h1;
    @(posedge clk);
    s_regs();
    s_power();
    s_enable();
    s_filter();
    s_qs();
    s_enloss();
    s_lock();
    s_fault();
    s_auto();
    final_report();
  end
endmodule : tb_drive_device_state_machine
